/* File: hdl/ppmc_defines.svh */
// Constants for the power management capability register pair
`ifndef PPMC_DEFINES_SVH
`define PPMC_DEFINES_SVH

// Configuration byte offsets of the two words
`define PPMC_CAP_OFS 8'h46
`define PPMC_CSR_OFS 8'h48

// Capabilities defaults chosen by the auxiliary supply strap
`define PPMC_CAP_AUX_DEF 16'hffc2
`define PPMC_CAP_NOAUX_DEF 16'h7e02
// Bits that never change: 14:9 and 5:0
`define PPMC_CAP_FIXED_MASK 16'h7e3f
`define PPMC_CAP_COLD_BIT 15
`define PPMC_CAP_AUX_HI 8
`define PPMC_CAP_AUX_LO 6
`define PPMC_CAP_AUX_ZERO 3'h0

// Control and status word layout
`define PPMC_CSR_RESET 16'h0000
`define PPMC_CSR_FLAG_BIT 15
`define PPMC_CSR_SCALE_HI 14
`define PPMC_CSR_SCALE_LO 13
`define PPMC_CSR_SEL_HI 12
`define PPMC_CSR_SEL_LO 9
`define PPMC_CSR_EN_BIT 8
`define PPMC_CSR_ZERO_HI 7
`define PPMC_CSR_ZERO_LO 2
`define PPMC_CSR_STATE_HI 1
`define PPMC_CSR_STATE_LO 0
`define PPMC_CSR_ZERO_FIELD 6'h00

// Byte lanes of a 16-bit configuration word
`define PPMC_BE_LO 0
`define PPMC_BE_HI 1

// Data select range and scale per index, two bits per entry
`define PPMC_SEL_RESET 4'h0
`define PPMC_SEL_MAX 4'h7
`define PPMC_SCALE_TABLE 16'h0000
`define PPMC_SCALE_NONE 2'h0

// Power state codes
`define PPMC_PS_D0 2'h0
`define PPMC_PS_D1 2'h1
`define PPMC_PS_D2 2'h2
`define PPMC_PS_D3 2'h3

// Cycles the strap synchroniser needs before it is sampled
`define PPMC_SETTLE_CYCLES 2'h2
`define PPMC_SETTLE_ZERO 2'h0
`define PPMC_SETTLE_STEP 2'h1

`endif

/* File: hdl/ppmc_pkg.sv */
// Types for the power management capability register pair
package ppmc_pkg;
  `include "ppmc_defines.svh"

  // One configuration access, valid for the cycle it is presented
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } ppmc_cfg_req_t;

  // Start-up sequence, one-hot
  typedef enum logic [2:0] {
    PPMC_INIT_SETTLE = 3'b001,
    PPMC_INIT_SAMPLE = 3'b010,
    PPMC_INIT_RUN = 3'b100
  } ppmc_init_t;

  typedef enum logic [1:0] {
    PPMC_D0 = `PPMC_PS_D0,
    PPMC_D1 = `PPMC_PS_D1,
    PPMC_D2 = `PPMC_PS_D2,
    PPMC_D3 = `PPMC_PS_D3
  } ppmc_pstate_t;
endpackage

/* File: hdl/ppmc_regs.sv */
// Power management capabilities and control/status words
`timescale 1ns/1ps
`include "ppmc_defines.svh"

// How it works
// - Supply present at reset release loads capabilities default ffc2.
// - Supply absent at reset release loads capabilities default 7e02.
// - Loader may override; without supply cold-wake bit and current forced 0.
// - Bits 14:11 read 1; bit 15 is the cold-wake capability.
// - Bits 10 and 9 read 1 for states D2 and D1.
// - Bits 8:6 report the auxiliary current need from defaults or the loader.
// - Bits 5, 4 and 3 of capabilities read 0.
// - Bits 2:0 read 010 for the interface revision.
// - The internal D3hot-to-D0 reset leaves the control word untouched.
// - Bus reset keeps wake flag and enable when cold-wake capable.
// - Wake events set the flag whatever the wake enable says.
// - Writing 1 clears the flag and releases wake; writing 0 does nothing.
// - With the wake enable clear the wake output stays inactive.
// - Bits 12:9 select a power-data entry; only 0 to 7 valid.
// - Bits 14:13 show the scale of the selected entry.
// - Control bits 7:2 always read 0.
// - Bits 1:0 hold the power state, 00 to 11 for D0 to D3.
module ppmc_regs (
  // Clock and power-up reset
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // Configuration access
  input wire ppmc_pkg::ppmc_cfg_req_t I_CFG,
  output logic O_CFG_ACK,
  output logic [15:0] O_CFG_RDATA,
  // Pins from the board
  input wire logic I_AUX_PRESENT,
  input wire logic I_PCI_RST_N,
  // Device-side events and loader
  input wire logic I_WAKE_EVENT,
  input wire logic I_EE_CAP_LOAD,
  input wire logic [15:0] I_EE_CAP_DATA,
  // Power management outputs
  output logic O_PME,
  output logic [1:0] O_POWER_STATE,
  output logic O_D3HOT_RESET
);
  import ppmc_pkg::*;

  logic aux_sync;
  logic pci_rst_n_sync;
  ppmc_init_t init_state_r;
  logic [1:0] settle_cnt_r;
  logic aux_present_r;
  logic [15:0] cap_r;
  logic [15:0] cap_ee_nxt;
  logic wake_flag_r;
  logic wake_flag_nxt;
  logic wake_en_r;
  logic wake_en_nxt;
  logic [3:0] data_sel_r;
  logic [1:0] data_scale;
  logic [1:0] pstate_r;
  logic [1:0] pstate_nxt;
  logic [15:0] csr_view;
  logic [15:0] rdata_nxt;
  logic pci_reset;
  logic sticky;
  logic accept;
  logic cap_hit;
  logic csr_hit;
  logic wr_hi;
  logic wr_lo;

  ppmc_sync2 #(.RST_VAL(1'b0)) u_aux_sync (
    .i_clk(I_MCLK),
    .i_srst(I_SRST),
    .i_d(I_AUX_PRESENT),
    .o_q(aux_sync)
  );

  ppmc_sync2 #(.RST_VAL(1'b1)) u_rst_sync (
    .i_clk(I_MCLK),
    .i_srst(I_SRST),
    .i_d(I_PCI_RST_N),
    .o_q(pci_rst_n_sync)
  );

  assign pci_reset = !pci_rst_n_sync;
  assign sticky = cap_r[`PPMC_CAP_COLD_BIT];
  // Accesses during bus reset or start-up are not taken
  assign accept = (init_state_r == PPMC_INIT_RUN) && !pci_reset &&
                  (I_CFG.wr || I_CFG.rd);
  assign cap_hit = (I_CFG.addr == `PPMC_CAP_OFS);
  assign csr_hit = (I_CFG.addr == `PPMC_CSR_OFS);
  assign wr_hi = accept && I_CFG.wr && csr_hit && I_CFG.be[`PPMC_BE_HI];
  assign wr_lo = accept && I_CFG.wr && csr_hit && I_CFG.be[`PPMC_BE_LO];

  // Start-up: let the strap synchroniser fill, sample once, then run
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      init_state_r <= PPMC_INIT_SETTLE;
      settle_cnt_r <= `PPMC_SETTLE_ZERO;
    end else begin
      case (init_state_r)
        PPMC_INIT_SETTLE: begin
          settle_cnt_r <= settle_cnt_r + `PPMC_SETTLE_STEP;
          if (settle_cnt_r == `PPMC_SETTLE_CYCLES) begin
            init_state_r <= PPMC_INIT_SAMPLE;
          end
        end
        PPMC_INIT_SAMPLE: begin
          init_state_r <= PPMC_INIT_RUN;
        end
        PPMC_INIT_RUN: begin
          init_state_r <= PPMC_INIT_RUN;
        end
        default: begin
          init_state_r <= PPMC_INIT_SETTLE;
        end
      endcase
    end
  end

  // Loader image: only cold-wake and current bits are programmable
  always_comb begin
    cap_ee_nxt = `PPMC_CAP_NOAUX_DEF & `PPMC_CAP_FIXED_MASK;
    cap_ee_nxt[`PPMC_CAP_COLD_BIT] = I_EE_CAP_DATA[`PPMC_CAP_COLD_BIT];
    cap_ee_nxt[`PPMC_CAP_AUX_HI:`PPMC_CAP_AUX_LO] =
      I_EE_CAP_DATA[`PPMC_CAP_AUX_HI:`PPMC_CAP_AUX_LO];
    if (!aux_present_r) begin
      cap_ee_nxt[`PPMC_CAP_COLD_BIT] = 1'b0;
      cap_ee_nxt[`PPMC_CAP_AUX_HI:`PPMC_CAP_AUX_LO] =
        `PPMC_CAP_AUX_ZERO;
    end
  end

  // Capabilities word; fixed bits 5:0 stay 000010 in both images
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      cap_r <= `PPMC_CAP_NOAUX_DEF;
      aux_present_r <= 1'b0;
    end else if (init_state_r == PPMC_INIT_SAMPLE) begin
      aux_present_r <= aux_sync;
      if (aux_sync) begin
        cap_r <= `PPMC_CAP_AUX_DEF;
      end else begin
        cap_r <= `PPMC_CAP_NOAUX_DEF;
      end
    end else if (init_state_r == PPMC_INIT_RUN && I_EE_CAP_LOAD) begin
      cap_r <= cap_ee_nxt;
    end
  end

  // Wake flag and enable; an event in the clearing cycle still sets
  always_comb begin
    wake_flag_nxt = wake_flag_r;
    wake_en_nxt = wake_en_r;
    if (wr_hi) begin
      wake_en_nxt = I_CFG.wdata[`PPMC_CSR_EN_BIT];
      if (I_CFG.wdata[`PPMC_CSR_FLAG_BIT]) begin
        wake_flag_nxt = 1'b0;
      end
    end
    if (pci_reset && !sticky) begin
      wake_flag_nxt = 1'b0;
      wake_en_nxt = 1'b0;
    end
    if (I_WAKE_EVENT) begin
      wake_flag_nxt = 1'b1;
    end
  end

  // Power-up reset always clears; bus reset only via the _nxt terms
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      wake_flag_r <= 1'b0;
      wake_en_r <= 1'b0;
    end else begin
      wake_flag_r <= wake_flag_nxt;
      wake_en_r <= wake_en_nxt;
    end
  end

  // Wake output follows the next flag and enable so it drops at once
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_PME <= 1'b0;
    end else begin
      O_PME <= wake_flag_nxt && wake_en_nxt;
    end
  end

  // Data select is cleared by any bus reset
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || pci_reset) begin
      data_sel_r <= `PPMC_SEL_RESET;
    end else if (wr_hi) begin
      data_sel_r <= I_CFG.wdata[`PPMC_CSR_SEL_HI:`PPMC_CSR_SEL_LO];
    end
  end

  // Scale per entry; unused indices report no scale
  always_comb begin
    if (data_sel_r <= `PPMC_SEL_MAX) begin
      data_scale = 2'(`PPMC_SCALE_TABLE >> {data_sel_r, 1'b0});
    end else begin
      data_scale = `PPMC_SCALE_NONE;
    end
  end

  always_comb begin
    pstate_nxt = pstate_r;
    if (wr_lo) begin
      pstate_nxt = I_CFG.wdata[`PPMC_CSR_STATE_HI:`PPMC_CSR_STATE_LO];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST || pci_reset) begin
      pstate_r <= `PPMC_PS_D0;
      O_POWER_STATE <= `PPMC_PS_D0;
    end else begin
      pstate_r <= pstate_nxt;
      O_POWER_STATE <= pstate_nxt;
    end
  end

  // Internal reset for the rest of the function; this word ignores it
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_D3HOT_RESET <= 1'b0;
    end else begin
      O_D3HOT_RESET <= wr_lo && (pstate_r == `PPMC_PS_D3) &&
                       (pstate_nxt == `PPMC_PS_D0);
    end
  end

  // Read view of the control word; reserved bits stay zero
  always_comb begin
    csr_view = `PPMC_CSR_RESET;
    csr_view[`PPMC_CSR_FLAG_BIT] = wake_flag_r;
    csr_view[`PPMC_CSR_SCALE_HI:`PPMC_CSR_SCALE_LO] = data_scale;
    csr_view[`PPMC_CSR_SEL_HI:`PPMC_CSR_SEL_LO] = data_sel_r;
    csr_view[`PPMC_CSR_EN_BIT] = wake_en_r;
    csr_view[`PPMC_CSR_ZERO_HI:`PPMC_CSR_ZERO_LO] =
      `PPMC_CSR_ZERO_FIELD;
    csr_view[`PPMC_CSR_STATE_HI:`PPMC_CSR_STATE_LO] = pstate_r;
  end

  // Read mux by address; unmapped offsets and writes answer zero
  always_comb begin
    rdata_nxt = `PPMC_CSR_RESET;
    if (accept && I_CFG.rd && cap_hit) begin
      rdata_nxt = cap_r;
    end else if (accept && I_CFG.rd && csr_hit) begin
      rdata_nxt = csr_view;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_CFG_ACK <= 1'b0;
      O_CFG_RDATA <= `PPMC_CSR_RESET;
    end else begin
      O_CFG_ACK <= accept;
      O_CFG_RDATA <= rdata_nxt;
    end
  end

  AST_CAP_AUX_ON: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    (init_state_r == PPMC_INIT_SAMPLE) && aux_sync
    |=> cap_r == `PPMC_CAP_AUX_DEF)
    else $error("capabilities default wrong with supply present");

  AST_CAP_AUX_OFF: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    (init_state_r == PPMC_INIT_SAMPLE) && !aux_sync
    |=> cap_r == `PPMC_CAP_NOAUX_DEF)
    else $error("capabilities default wrong with supply absent");

  AST_NOAUX_FORCE: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    (init_state_r == PPMC_INIT_RUN) && !aux_present_r
    |-> !cap_r[`PPMC_CAP_COLD_BIT] &&
        cap_r[`PPMC_CAP_AUX_HI:`PPMC_CAP_AUX_LO] == `PPMC_CAP_AUX_ZERO)
    else $error("cold wake or current set without supply");

  AST_CAP_FIXED: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    (init_state_r == PPMC_INIT_RUN) && I_EE_CAP_LOAD
    |=> (cap_r & `PPMC_CAP_FIXED_MASK) ==
        (`PPMC_CAP_NOAUX_DEF & `PPMC_CAP_FIXED_MASK))
    else $error("fixed capability bits changed by loader");

  AST_CAP_READ: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    accept && I_CFG.rd && cap_hit && !I_EE_CAP_LOAD
    |=> O_CFG_ACK && O_CFG_RDATA == cap_r)
    else $error("capabilities read returned wrong value");

  AST_D3_KEEP: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    O_D3HOT_RESET && !I_WAKE_EVENT && !pci_reset && !accept
    |=> $stable(wake_en_r) && $stable(data_sel_r) && $stable(pstate_r))
    else $error("control word disturbed by internal reset");

  AST_STICKY: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    pci_reset && sticky && !I_WAKE_EVENT
    |=> $stable(wake_flag_r) && $stable(wake_en_r))
    else $error("sticky wake bits lost on bus reset");

  AST_NONSTICKY: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    pci_reset && !sticky && !I_WAKE_EVENT
    |=> !wake_flag_r && !wake_en_r && pstate_r == `PPMC_PS_D0 &&
        data_sel_r == `PPMC_SEL_RESET)
    else $error("control word not cleared by bus reset");

  AST_WAKE_SET: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    I_WAKE_EVENT |=> wake_flag_r)
    else $error("wake event did not set flag");

  AST_W1C: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    wr_hi && I_CFG.wdata[`PPMC_CSR_FLAG_BIT] && !I_WAKE_EVENT
    |=> !wake_flag_r ##0 !O_PME)
    else $error("write of one did not clear flag and wake output");

  AST_W0_KEEP: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    wr_hi && !I_CFG.wdata[`PPMC_CSR_FLAG_BIT] && wake_flag_r
    |=> wake_flag_r)
    else $error("write of zero changed wake flag");

  AST_PME_GATE: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    O_PME == (wake_flag_r && wake_en_r))
    else $error("wake output disagrees with flag and enable");

  AST_SCALE: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    accept && I_CFG.rd && csr_hit && data_sel_r > `PPMC_SEL_MAX
    |=> O_CFG_RDATA[`PPMC_CSR_SCALE_HI:`PPMC_CSR_SCALE_LO] ==
        `PPMC_SCALE_NONE)
    else $error("reserved data index reported a scale");

  AST_RESERVED: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    O_CFG_ACK |->
    O_CFG_RDATA[`PPMC_CSR_ZERO_HI:`PPMC_CSR_ZERO_LO] == `PPMC_CSR_ZERO_FIELD
    || $past(cap_hit))
    else $error("reserved control bits read nonzero");

  AST_PSTATE: assert property (
    @(posedge I_MCLK) disable iff (I_SRST)
    wr_lo ##1 !pci_reset
    |-> O_POWER_STATE ==
        $past(I_CFG.wdata[`PPMC_CSR_STATE_HI:`PPMC_CSR_STATE_LO]))
    else $error("power state write not reflected");
endmodule

/* File: hdl/ppmc_sync2.sv */
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/1ps
module ppmc_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  logic sync_r;

  // The first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule

/* File: verif/ppmc_host_model.sv */
// Configuration host model that issues single-cycle accesses
`timescale 1ns/1ps
module ppmc_host_model
  import ppmc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Answer from the register pair
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  // Request to the register pair
  output ppmc_cfg_req_t o_cfg
);
  initial begin
    o_cfg = '0;
  end

  // One-cycle request; the answer is taken at the first falling edge
  // that shows ACK, within a bounded wait
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [1:0] b, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge i_clk);
    o_cfg.wr = w;
    o_cfg.rd = !w;
    o_cfg.addr = a;
    o_cfg.be = b;
    o_cfg.wdata = d; // Write-one-clear and state codes as given
    @(negedge i_clk);
    o_cfg.wr = 1'b0;
    o_cfg.rd = 1'b0;
    // Released lines show the inverse so stale values are not trusted
    o_cfg.addr = ~a;
    o_cfg.wdata = ~d;
    while (i_ack !== 1'b1 && n < 4) begin
      n++;
      @(negedge i_clk);
    end
    q = i_rdata;
    ok = (i_ack === 1'b1);
  endtask
endmodule

/* File: verif/test_ppmc_regs.sv */
// Self-checking bench for the power management register pair
`timescale 1ns/1ps
module test_ppmc_regs;
  import ppmc_pkg::*;
  logic mclk = 1'b1;
  logic srst = 1'b1;
  logic aux = 1'b1;
  logic pci_rst_n = 1'b1;
  logic wake = 1'b0;
  logic ee_load = 1'b0;
  logic [15:0] ee_data = 16'h0000;
  ppmc_cfg_req_t cfg;
  logic ack;
  logic [15:0] rdata;
  logic pme;
  logic [1:0] pstate;
  logic d3rst;
  logic [15:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int d3_count = 0;

  always #2.5 mclk = ~mclk;

  ppmc_host_model ppmc_host_model_inst (
    .i_clk(mclk), .i_ack(ack), .i_rdata(rdata), .o_cfg(cfg)
  );

  ppmc_regs ppmc_regs_inst (
    .I_MCLK(mclk), .I_SRST(srst), .I_CFG(cfg), .O_CFG_ACK(ack),
    .O_CFG_RDATA(rdata), .I_AUX_PRESENT(aux), .I_PCI_RST_N(pci_rst_n),
    .I_WAKE_EVENT(wake), .I_EE_CAP_LOAD(ee_load),
    .I_EE_CAP_DATA(ee_data), .O_PME(pme), .O_POWER_STATE(pstate),
    .O_D3HOT_RESET(d3rst)
  );

  always @(negedge mclk) begin
    if (d3rst === 1'b1) begin
      d3_count++;
    end
  end

  task report_and_stop;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end

  task chk(input string name, input logic [15:0] exp,
           input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task rd(input logic [7:0] a, input logic [15:0] exp);
    logic ok;
    ppmc_host_model_inst.access(1'b0, a, 2'h3, 16'h0000, q, ok);
    chk("ack", 16'h0001, {15'h0, ok});
    chk("rdata", exp, q);
  endtask

  task wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    logic ok;
    ppmc_host_model_inst.access(1'b1, a, b, d, q, ok);
    chk("ack", 16'h0001, {15'h0, ok});
  endtask

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Strap held steady through reset and the settle window
  task por(input logic a);
    @(negedge mclk);
    aux = a;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(6);
  endtask

  task busrst;
    @(negedge mclk);
    pci_rst_n = 1'b0;
    cyc(4);
    pci_rst_n = 1'b1;
    cyc(4);
  endtask

  task pulse_wake;
    @(negedge mclk);
    wake = 1'b1;
    @(negedge mclk);
    wake = 1'b0;
  endtask

  task ee(input logic [15:0] d);
    @(negedge mclk);
    ee_data = d;
    ee_load = 1'b1;
    @(negedge mclk);
    ee_load = 1'b0;
  endtask

  initial begin
    por(1'b1);
    rd(8'h46, 16'hffc2);
    rd(8'h48, 16'h0000);
    wr(8'h46, 2'h3, 16'h0000);
    rd(8'h46, 16'hffc2);
    rd(8'h4a, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(8'h48, 2'h1, 16'(s));
      rd(8'h48, 16'(s));
      chk("pstate", 16'(s), {14'h0, pstate});
    end
    // Index 8 is reserved: accepted, but it must report no scale
    wr(8'h48, 2'h2, 16'h1100);
    rd(8'h48, 16'h1103);
    // Scale bits and zero bits written as ones must not stick
    wr(8'h48, 2'h3, 16'h6fff);
    rd(8'h48, 16'h0f03);
    wr(8'h48, 2'h1, 16'h0000);
    // Let the pulse counter see the falling edge before reading it
    cyc(1);
    chk("d3 pulses", 16'h0001, 16'(d3_count));
    rd(8'h48, 16'h0f00);
    pulse_wake;
    chk("pme", 16'h0001, {15'h0, pme});
    wr(8'h48, 2'h2, 16'h0f00);
    rd(8'h48, 16'h8f00);
    chk("pme", 16'h0001, {15'h0, pme});
    wr(8'h48, 2'h2, 16'h8f00);
    chk("pme", 16'h0000, {15'h0, pme});
    rd(8'h48, 16'h0f00);
    wr(8'h48, 2'h2, 16'h0e00);
    pulse_wake;
    chk("pme", 16'h0000, {15'h0, pme});
    rd(8'h48, 16'h8e00);
    wr(8'h48, 2'h2, 16'h8f00);
    pulse_wake;
    busrst;
    rd(8'h48, 16'h8100);
    chk("pme", 16'h0001, {15'h0, pme});
    por(1'b0);
    rd(8'h46, 16'h7e02);
    rd(8'h48, 16'h0000);
    ee(16'hffff);
    rd(8'h46, 16'h7e02);
    wr(8'h48, 2'h3, 16'h0101);
    pulse_wake;
    busrst;
    rd(8'h48, 16'h0000);
    chk("pme", 16'h0000, {15'h0, pme});
    por(1'b1);
    ee(16'h0000);
    rd(8'h46, 16'h7e02);
    ee(16'hffff);
    rd(8'h46, 16'hffc2);
    report_and_stop;
  end
endmodule
